// ==== shared/serial_port_pkg.sv ====
package serial_port_pkg;

    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    // Register byte offsets
    localparam logic [7:0] OFF_CHANNEL_STATUS = 8'h00;
    localparam logic [7:0] OFF_RECEIVE_HOLDING = 8'h04;
    localparam logic [7:0] OFF_TRANSMIT_HOLDING = 8'h08;
    localparam logic [7:0] OFF_BAUD_DIVIDER = 8'h0c;
    localparam logic [7:0] OFF_RECEIVE_IDLE_LIMIT = 8'h10;
    localparam logic [7:0] OFF_CONTROL = 8'h14;
    localparam logic [7:0] OFF_COMMAND = 8'h18;
    localparam logic [7:0] OFF_EVENT_STATUS = 8'h1c;
    localparam logic [7:0] OFF_EVENT_MASK = 8'h20;

    // Channel status bit positions
    localparam int ST_RX_CHAR_AVAILABLE = 0;
    localparam int ST_TX_HOLDING_FREE = 1;
    localparam int ST_RX_TIMEOUT = 8;
    localparam int ST_TX_ALL_DRAINED = 9;
    localparam int ST_RETRY_LIMIT = 10;
    localparam int ST_TX_DMA_BUFFER_DRAINED = 11;
    localparam int ST_RX_DMA_BUFFER_FILLED = 12;
    localparam int ST_NO_ACKNOWLEDGE_SEEN = 13;
    localparam int ST_MODEM_CHANGE_LSB = 16;
    localparam int ST_MODEM_LEVEL_LSB = 20;
    localparam int ST_PHASE_CODE_ERROR = 24;
    localparam int MODEM_LINES = 4;

    // Holding register fields
    localparam int CHAR_W = 9;
    localparam int MARKER_BIT = 15;

    // Baud divider and receive idle limit fields
    localparam int DIVISOR_W = 16;
    localparam int FRACTION_LSB = 16;
    localparam int FRACTION_W = 3;
    localparam int IDLE_LIMIT_W = 16;

    // Control register fields and reset values
    localparam int CTL_TX_ENABLE = 0;
    localparam int CTL_RX_ENABLE = 1;
    localparam int CTL_MODE_LSB = 2;
    localparam int CTL_RATIO_LSB = 4;
    localparam int RATIO_W = 11;
    localparam logic [RATIO_W-1:0] RATIO_RESET = 11'h174;

    // Command register bits
    localparam int CMD_CLEAR_STATUS = 0;
    localparam int CMD_CLEAR_NO_ACK = 1;
    localparam int CMD_CLEAR_RETRY_LIMIT = 2;

    // Event status and mask bits
    localparam int EV_RX_CHAR = 0;
    localparam int EV_TX_DRAINED = 1;
    localparam int EV_TIMEOUT = 2;
    localparam int EV_RETRY_LIMIT = 3;
    localparam int EV_NO_ACK = 4;
    localparam int EV_MODEM_CHANGE = 5;
    localparam int EV_PHASE_ERROR = 6;
    localparam int EV_W = 7;

    // Baud arithmetic, in eighths of a selected-clock cycle
    localparam logic [31:0] OVERSAMPLE_FULL = 32'h10;
    localparam logic [31:0] OVERSAMPLE_HALF = 32'h8;
    localparam logic [31:0] FRACTION_STEP = 32'h8;

    // Frame: start, marker, nine data bits, stop
    localparam int FRAME_BITS = 12;
    localparam int BIT_CNT_W = 4;
    localparam logic [BIT_CNT_W-1:0] LAST_BIT = 4'hb;

    typedef enum logic [1:0] {
        MODE_ASYNC_X16,
        MODE_ASYNC_X8,
        MODE_SYNC,
        MODE_SMART_CARD
    } baud_mode_t;

    typedef enum logic {
        RX_IDLE,
        RX_RUN
    } rx_state_t;

endpackage

// ==== logic/serial_port_status_data_baud.sv ====
// Added by the designer: the plain strobed port and the register offsets.
`timescale 1ns/1ps
// Summary of operation
// - Transmitter-drained flag is low while holding or shift register busy, or disabled.
// - Retry-limit flag is sticky until the clear-retry-limit command.
// - Transmit DMA buffer-drained status mirrors its input, one meaning active.
// - Receive DMA buffer-filled status mirrors its input, one meaning active.
// - No-acknowledge flag is sticky until the clear-no-ack command.
// - Each modem line toggle sets its change flag; status read clears all four.
// - Live modem line levels are readable, zero low and one high.
// - Phase-code error flag is sticky until the clear-status command.
// - Receive holding returns last nine-bit character, valid while character available.
// - Receive holding bit 15 shows command marker one, data marker zero.
// - Software writes next character when holding is free; sent after current one.
// - Write bit 15 selects command or data delimiter for that character.
// - Divisor zero stops baud clock; otherwise divide by mode factor times divisor.
// - Three-bit fraction adds that many eighths to the divisor; zero disables.
// - Idle limit zero disables time-out; otherwise time-out after that many bits.
// - Reading receive holding clears character available until next character.
module serial_port_status_data_baud
    import serial_port_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic [ADDR_W-1:0] i_addr,
    input wire logic [DATA_W-1:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [DATA_W-1:0] o_rdata,
    output logic o_irq,
    input wire logic i_rxd,
    output logic o_txd,
    input wire logic i_ring,
    input wire logic i_set_ready,
    input wire logic i_carrier,
    input wire logic i_send_clear,
    input wire logic i_retry_limit_hit,
    input wire logic i_no_ack_pulse,
    input wire logic i_phase_code_error_pulse,
    input wire logic i_tx_dma_buffer_drained,
    input wire logic i_rx_dma_buffer_filled
);

    // Returns {tick, next accumulator}; period zero holds the clock still
    function automatic logic [32:0] acc_step(input logic [31:0] acc, input logic [31:0] period);
        logic [31:0] sum;
        sum = acc + FRACTION_STEP;
        if (period == 32'h0)
            acc_step = {1'b0, 32'h0};
        else if (sum >= period)
            acc_step = {1'b1, sum - period};
        else
            acc_step = {1'b0, sum};
    endfunction

    logic [DATA_W-1:0] o_rdata_ff;
    logic o_irq_ff;
    logic o_txd_ff;
    logic tx_enable_ff;
    logic rx_enable_ff;
    baud_mode_t mode_ff;
    logic [RATIO_W-1:0] ratio_ff;
    logic [DIVISOR_W-1:0] baud_divisor_ff;
    logic [FRACTION_W-1:0] baud_fraction_ff;
    logic [IDLE_LIMIT_W-1:0] rx_idle_limit_ff;
    logic [CHAR_W-1:0] tx_character_ff;
    logic tx_command_marker_ff;
    logic hold_full_ff;
    logic [FRAME_BITS-1:0] tx_shift_ff;
    logic [BIT_CNT_W-1:0] tx_count_ff;
    logic tx_busy_ff;
    logic [31:0] tx_acc_ff;
    logic [31:0] rx_acc_ff;
    rx_state_t rx_state_ff;
    logic [BIT_CNT_W-1:0] rx_count_ff;
    logic [FRAME_BITS-2:0] rx_shift_ff;
    logic [CHAR_W-1:0] rx_character_ff;
    logic rx_command_marker_ff;
    logic rx_char_available_ff;
    logic rx_meta_ff;
    logic rx_sync_ff;
    logic [MODEM_LINES-1:0] modem_meta_ff;
    logic [MODEM_LINES-1:0] modem_sync_ff;
    logic [MODEM_LINES-1:0] modem_prev_ff;
    logic [MODEM_LINES-1:0] modem_change_ff;
    logic retry_limit_ff;
    logic no_acknowledge_seen_ff;
    logic phase_code_error_ff;
    logic rx_timeout_ff;
    logic idle_armed_ff;
    logic [IDLE_LIMIT_W-1:0] idle_count_ff;
    logic drained_prev_ff;
    logic [EV_W-1:0] event_ff;
    logic [EV_W-1:0] mask_ff;

    // Register decode
    wire wr_status = i_wr && (i_addr == OFF_CHANNEL_STATUS);
    wire wr_thr = i_wr && (i_addr == OFF_TRANSMIT_HOLDING);
    wire wr_baud = i_wr && (i_addr == OFF_BAUD_DIVIDER);
    wire wr_idle = i_wr && (i_addr == OFF_RECEIVE_IDLE_LIMIT);
    wire wr_ctl = i_wr && (i_addr == OFF_CONTROL);
    wire wr_cmd = i_wr && (i_addr == OFF_COMMAND);
    wire wr_event = i_wr && (i_addr == OFF_EVENT_STATUS);
    wire wr_mask = i_wr && (i_addr == OFF_EVENT_MASK);
    wire rd_status = i_rd && (i_addr == OFF_CHANNEL_STATUS);
    wire rd_rhr = i_rd && (i_addr == OFF_RECEIVE_HOLDING);
    wire cmd_clear_status = wr_cmd && i_wdata[CMD_CLEAR_STATUS];
    wire cmd_clear_no_ack = wr_cmd && i_wdata[CMD_CLEAR_NO_ACK];
    wire cmd_clear_retry = wr_cmd && i_wdata[CMD_CLEAR_RETRY_LIMIT];

    // Baud period in eighths of a clock
    wire [31:0] base8 = {13'h0, baud_divisor_ff, baud_fraction_ff};
    wire [31:0] period8 =
        (baud_divisor_ff == '0) ? 32'h0 :
        (mode_ff == MODE_ASYNC_X16) ? 32'(base8 * OVERSAMPLE_FULL) :
        (mode_ff == MODE_ASYNC_X8) ? 32'(base8 * OVERSAMPLE_HALF) :
        (mode_ff == MODE_SYNC) ? base8 :
        32'(base8 * {21'h0, ratio_ff});

    wire [32:0] tx_step = acc_step(tx_acc_ff, period8);
    wire [32:0] rx_step = acc_step(rx_acc_ff, period8);
    wire bit_tick = tx_step[32];
    wire rx_tick = rx_step[32];

    // Transmit path
    // A stopped baud clock leaves the character waiting, line idle
    wire tx_load = hold_full_ff && !tx_busy_ff && tx_enable_ff && (period8 != 32'h0);
    wire tx_holding_free = tx_enable_ff && !hold_full_ff;
    wire tx_accept = wr_thr && tx_holding_free;
    wire tx_all_drained = tx_enable_ff && !hold_full_ff && !tx_busy_ff;
    wire tx_last = tx_busy_ff && bit_tick && (tx_count_ff == LAST_BIT);
    wire [FRAME_BITS-1:0] tx_frame = {1'b1, tx_character_ff, tx_command_marker_ff, 1'b0};

    // Receive path
    wire [FRAME_BITS-2:0] rx_shift_in = {rx_sync_ff, rx_shift_ff[FRAME_BITS-2:1]};
    wire rx_start = (rx_state_ff == RX_IDLE) && rx_enable_ff && !rx_sync_ff && (period8 != 0);
    wire rx_false_start = rx_tick && (rx_count_ff == '0) && rx_sync_ff;
    wire rx_done = (rx_state_ff == RX_RUN) && rx_tick && (rx_count_ff == LAST_BIT);

    // Modem lines and idle time-out
    wire [MODEM_LINES-1:0] modem_edge = modem_sync_ff ^ modem_prev_ff;
    wire idle_expire = idle_armed_ff && bit_tick && (rx_state_ff == RX_IDLE)
        && (idle_count_ff + 16'h1 == rx_idle_limit_ff);

    wire [DATA_W-1:0] status_word = {
        7'h0, phase_code_error_ff, modem_sync_ff, modem_change_ff, 2'h0,
        no_acknowledge_seen_ff, i_rx_dma_buffer_filled, i_tx_dma_buffer_drained,
        retry_limit_ff, tx_all_drained, rx_timeout_ff, 6'h0, tx_holding_free,
        rx_char_available_ff};
    wire [DATA_W-1:0] rhr_word = {16'h0, rx_command_marker_ff, 6'h0, rx_character_ff};
    wire [DATA_W-1:0] ctl_word = {17'h0, ratio_ff, mode_ff, rx_enable_ff, tx_enable_ff};

    wire [DATA_W-1:0] read_mux;
    assign read_mux =
        (i_addr == OFF_CHANNEL_STATUS) ? status_word :
        (i_addr == OFF_RECEIVE_HOLDING) ? rhr_word :
        (i_addr == OFF_BAUD_DIVIDER) ? {13'h0, baud_fraction_ff, baud_divisor_ff} :
        (i_addr == OFF_RECEIVE_IDLE_LIMIT) ? {16'h0, rx_idle_limit_ff} :
        (i_addr == OFF_CONTROL) ? ctl_word :
        (i_addr == OFF_EVENT_STATUS) ? {25'h0, event_ff} :
        (i_addr == OFF_EVENT_MASK) ? {25'h0, mask_ff} :
        32'h0;

    wire [EV_W-1:0] event_set = {phase_code_error_pulse_w(), |modem_edge, i_no_ack_pulse,
        i_retry_limit_hit, idle_expire, tx_all_drained && !drained_prev_ff, rx_done};
    wire [EV_W-1:0] event_clear = wr_event ? i_wdata[EV_W-1:0] : '0;
    wire [EV_W-1:0] nxt_event_ff = event_set | (event_ff & ~event_clear);

    function automatic logic phase_code_error_pulse_w();
        phase_code_error_pulse_w = i_phase_code_error_pulse;
    endfunction

    // Bus slave and configuration
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n)
        begin
            o_rdata_ff <= '0;
            tx_enable_ff <= 1'b0;
            rx_enable_ff <= 1'b0;
            mode_ff <= MODE_ASYNC_X16;
            ratio_ff <= RATIO_RESET;
            baud_divisor_ff <= '0;
            baud_fraction_ff <= '0;
            rx_idle_limit_ff <= '0;
            mask_ff <= '0;
            event_ff <= '0;
            o_irq_ff <= 1'b0;
            drained_prev_ff <= 1'b0;
        end
        else
        begin
            o_rdata_ff <= i_rd ? read_mux : '0;
            if (wr_ctl)
            begin
                tx_enable_ff <= i_wdata[CTL_TX_ENABLE];
                rx_enable_ff <= i_wdata[CTL_RX_ENABLE];
                mode_ff <= baud_mode_t'(i_wdata[CTL_MODE_LSB +: 2]);
                ratio_ff <= i_wdata[CTL_RATIO_LSB +: RATIO_W];
            end
            if (wr_baud)
            begin
                baud_divisor_ff <= i_wdata[DIVISOR_W-1:0];
                baud_fraction_ff <= i_wdata[FRACTION_LSB +: FRACTION_W];
            end
            if (wr_idle)
                rx_idle_limit_ff <= i_wdata[IDLE_LIMIT_W-1:0];
            if (wr_mask)
                mask_ff <= i_wdata[EV_W-1:0];
            event_ff <= nxt_event_ff;
            o_irq_ff <= |(nxt_event_ff & mask_ff);
            drained_prev_ff <= tx_all_drained;
        end
    end

    // Transmitter: holding register, shift register, bit clock
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n)
        begin
            tx_character_ff <= '0;
            tx_command_marker_ff <= 1'b0;
            hold_full_ff <= 1'b0;
            tx_shift_ff <= '1;
            tx_count_ff <= '0;
            tx_busy_ff <= 1'b0;
            tx_acc_ff <= '0;
            o_txd_ff <= 1'b1;
        end
        else
        begin
            // Restart the bit clock at each load so the start bit is full length
            tx_acc_ff <= tx_load ? 32'h0 : tx_step[31:0];
            if (tx_accept)
            begin
                tx_character_ff <= i_wdata[CHAR_W-1:0];
                tx_command_marker_ff <= i_wdata[MARKER_BIT];
                hold_full_ff <= 1'b1;
            end
            else if (tx_load || !tx_enable_ff)
                hold_full_ff <= 1'b0;
            if (!tx_enable_ff)
            begin
                tx_busy_ff <= 1'b0;
                o_txd_ff <= 1'b1;
            end
            else if (tx_load)
            begin
                tx_shift_ff <= tx_frame;
                tx_count_ff <= '0;
                tx_busy_ff <= 1'b1;
                o_txd_ff <= 1'b0;
            end
            else if (tx_last)
            begin
                tx_busy_ff <= 1'b0;
                o_txd_ff <= 1'b1;
            end
            else if (tx_busy_ff && bit_tick)
            begin
                tx_shift_ff <= {1'b1, tx_shift_ff[FRAME_BITS-1:1]};
                tx_count_ff <= tx_count_ff + 4'h1;
                o_txd_ff <= tx_shift_ff[1];
            end
        end
    end

    // Receiver
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n)
        begin
            rx_meta_ff <= 1'b1;
            rx_sync_ff <= 1'b1;
            rx_state_ff <= RX_IDLE;
            rx_acc_ff <= '0;
            rx_count_ff <= '0;
            rx_shift_ff <= '0;
            rx_character_ff <= '0;
            rx_command_marker_ff <= 1'b0;
            rx_char_available_ff <= 1'b0;
        end
        else
        begin
            rx_meta_ff <= i_rxd;
            rx_sync_ff <= rx_meta_ff;
            // Arrival wins over a read in the same cycle
            if (rx_done)
                rx_char_available_ff <= 1'b1;
            else if (rd_rhr)
                rx_char_available_ff <= 1'b0;
            case (rx_state_ff)
                RX_IDLE:
                begin
                    if (rx_start)
                    begin
                        rx_state_ff <= RX_RUN;
                        rx_acc_ff <= period8 >> 1;
                        // One clock per bit: no mid-start sample exists, start counts as seen
                        rx_count_ff <= (period8 <= FRACTION_STEP) ? 4'h1 : 4'h0;
                    end
                end
                RX_RUN:
                begin
                    rx_acc_ff <= rx_step[31:0];
                    if (!rx_enable_ff || period8 == 32'h0 || rx_false_start)
                        rx_state_ff <= RX_IDLE;
                    else if (rx_done)
                    begin
                        rx_character_ff <= rx_shift_in[CHAR_W:1];
                        rx_command_marker_ff <= rx_shift_in[0];
                        rx_state_ff <= RX_IDLE;
                    end
                    else if (rx_tick)
                    begin
                        if (rx_count_ff != '0)
                            rx_shift_ff <= rx_shift_in;
                        rx_count_ff <= rx_count_ff + 4'h1;
                    end
                end
                default:
                    rx_state_ff <= RX_IDLE;
            endcase
        end
    end

    // Sticky status flags, modem lines, idle time-out
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n)
        begin
            modem_meta_ff <= '0;
            modem_sync_ff <= '0;
            modem_prev_ff <= '0;
            modem_change_ff <= '0;
            retry_limit_ff <= 1'b0;
            no_acknowledge_seen_ff <= 1'b0;
            phase_code_error_ff <= 1'b0;
            rx_timeout_ff <= 1'b0;
            idle_armed_ff <= 1'b0;
            idle_count_ff <= '0;
        end
        else
        begin
            modem_meta_ff <= {i_send_clear, i_carrier, i_set_ready, i_ring};
            modem_sync_ff <= modem_meta_ff;
            modem_prev_ff <= modem_sync_ff;
            modem_change_ff <= modem_edge | (modem_change_ff & {MODEM_LINES{!rd_status}});
            retry_limit_ff <= i_retry_limit_hit || (retry_limit_ff && !cmd_clear_retry);
            no_acknowledge_seen_ff <= i_no_ack_pulse
                || (no_acknowledge_seen_ff && !cmd_clear_no_ack);
            phase_code_error_ff <= i_phase_code_error_pulse
                || (phase_code_error_ff && !cmd_clear_status);
            rx_timeout_ff <= idle_expire || (rx_timeout_ff && !cmd_clear_status);
            // Time-out counts bit periods after the last character
            if (rx_done && rx_idle_limit_ff != '0)
            begin
                idle_armed_ff <= 1'b1;
                idle_count_ff <= '0;
            end
            else if (rx_idle_limit_ff == '0 || idle_expire || rx_state_ff == RX_RUN)
            begin
                idle_armed_ff <= 1'b0;
                idle_count_ff <= '0;
            end
            else if (idle_armed_ff && bit_tick)
                idle_count_ff <= idle_count_ff + 16'h1;
        end
    end

    assign o_rdata = o_rdata_ff;
    assign o_irq = o_irq_ff;
    assign o_txd = o_txd_ff;

    // Checks
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);

    sequence s_line_toggle;
        modem_sync_ff[MODEM_LINES-1] != modem_prev_ff[MODEM_LINES-1];
    endsequence

    property p_tx_busy_not_drained;
        (hold_full_ff || tx_busy_ff || !tx_enable_ff) |-> !status_word[ST_TX_ALL_DRAINED];
    endproperty
    a_tx_busy_not_drained: assert property (p_tx_busy_not_drained)
        else $error("drained flag high while busy or disabled");

    property p_tx_drained_after_write;
        tx_accept && period8 != 32'h0 |=> !status_word[ST_TX_ALL_DRAINED] ##1 tx_busy_ff;
    endproperty
    a_tx_drained_after_write: assert property (p_tx_drained_after_write)
        else $error("drained flag or load wrong after write");

    property p_retry_sticky;
        retry_limit_ff && !cmd_clear_retry |=> status_word[ST_RETRY_LIMIT];
    endproperty
    a_retry_sticky: assert property (p_retry_sticky)
        else $error("retry limit flag dropped without command");

    property p_dma_mirror;
        i_rd && i_addr == OFF_CHANNEL_STATUS |=>
            o_rdata[ST_TX_DMA_BUFFER_DRAINED] == $past(i_tx_dma_buffer_drained)
            && o_rdata[ST_RX_DMA_BUFFER_FILLED] == $past(i_rx_dma_buffer_filled);
    endproperty
    a_dma_mirror: assert property (p_dma_mirror)
        else $error("dma status does not mirror inputs");

    property p_no_ack_set;
        i_no_ack_pulse |=> no_acknowledge_seen_ff;
    endproperty
    a_no_ack_set: assert property (p_no_ack_set)
        else $error("no-acknowledge flag not set");

    property p_line_change;
        s_line_toggle |=> modem_change_ff[MODEM_LINES-1];
    endproperty
    a_line_change: assert property (p_line_change)
        else $error("line change flag not set after toggle");

    property p_phase_error;
        i_phase_code_error_pulse |=> phase_code_error_ff [*2] or
            (phase_code_error_ff ##1 cmd_clear_status);
    endproperty
    a_phase_error: assert property (p_phase_error)
        else $error("phase error flag not held");

    property p_rhr_read_clears;
        rd_rhr && !rx_done |=> !rx_char_available_ff;
    endproperty
    a_rhr_read_clears: assert property (p_rhr_read_clears)
        else $error("character available not cleared by read");

    property p_rhr_data;
        rd_rhr |=> o_rdata[CHAR_W-1:0] == $past(rx_character_ff)
            && o_rdata[MARKER_BIT] == $past(rx_command_marker_ff);
    endproperty
    a_rhr_data: assert property (p_rhr_data)
        else $error("receive holding read data wrong");

    property p_divisor_zero_stops;
        baud_divisor_ff == '0 |-> !bit_tick && !rx_tick;
    endproperty
    a_divisor_zero_stops: assert property (p_divisor_zero_stops)
        else $error("baud tick with zero divisor");

    property p_marker_sent;
        tx_load |=> tx_shift_ff[1] == $past(tx_command_marker_ff) && !o_txd_ff;
    endproperty
    a_marker_sent: assert property (p_marker_sent)
        else $error("frame marker or start bit wrong");

endmodule

// ==== verif/serial_peer.sv ====
`timescale 1ns/1ps
module serial_peer (
    input wire logic i_clk,
    input wire logic i_txd,
    output logic o_rxd,
    output logic [11:0] o_got
);
    logic [11:0] sh;
    int n;
    initial
    begin
        o_rxd = 1'b1;
        n = 0;
        sh = '0;
        o_got = '0;
    end
    // Sample on falling edge, mid-bit at one clock per bit
    always @(negedge i_clk)
    begin
        if (n == 0 && i_txd === 1'b0)
            n = 1;
        else if (n > 0)
            n = n + 1;
        if (n > 0)
            sh = {i_txd, sh[11:1]};
        if (n == 12)
        begin
            o_got = sh;
            n = 0;
        end
    end
    // Line returns high after stop, as with a pull-up
    task automatic send(input logic [8:0] d, input logic m);
        logic [11:0] f;
        f = {1'b1, d, m, 1'b0};
        for (int i = 0; i < 12; i++)
        begin
            @(posedge i_clk);
            o_rxd <= f[i];
        end
        @(posedge i_clk);
    endtask
endmodule

// ==== verif/tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
    import serial_port_pkg::*;
    logic i_clk, i_rst_n, i_wr, i_rd, i_ring, i_set_ready, i_carrier, i_send_clear, rxd;
    logic i_retry_limit_hit, i_no_ack_pulse, i_phase_code_error_pulse, o_irq, o_txd;
    logic i_tx_dma_buffer_drained, i_rx_dma_buffer_filled;
    logic [ADDR_W-1:0] i_addr;
    logic [DATA_W-1:0] i_wdata, o_rdata, d, r;
    logic [11:0] got;
    logic [3:0] pv;
    int seed = 32'h37192355;
    int error_cnt = 0;
    int n_checks = 0;
    int cyc = 0;
    serial_port_status_data_baud dut_u (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_irq(o_irq),
        .i_rxd(rxd), .o_txd(o_txd), .i_ring(i_ring), .i_set_ready(i_set_ready),
        .i_carrier(i_carrier), .i_send_clear(i_send_clear),
        .i_retry_limit_hit(i_retry_limit_hit), .i_no_ack_pulse(i_no_ack_pulse),
        .i_phase_code_error_pulse(i_phase_code_error_pulse),
        .i_tx_dma_buffer_drained(i_tx_dma_buffer_drained),
        .i_rx_dma_buffer_filled(i_rx_dma_buffer_filled));
    serial_peer peer_u (.i_clk(i_clk), .i_txd(o_txd), .o_rxd(rxd), .o_got(got));
    initial
    begin
        i_clk = 1'b0;
        forever #50 i_clk = ~i_clk;
    end
    function automatic logic [31:0] hold(input logic [8:0] c, input logic m);
        return {16'h0, m, 6'h0, c};
    endfunction
    task automatic chk(input string nm, input logic [31:0] m, e, g);
        n_checks++;
        if ((g & m) !== (e & m))
        begin
            error_cnt++;
            $display("unexpected %s exp %h got %h", nm, e & m, g & m);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] w);
        @(posedge i_clk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= w;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe
    task automatic rc(input string nm, input logic [7:0] a, input logic [31:0] m, e);
        @(posedge i_clk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1 d = o_rdata;
        chk(nm, m, e, d);
    endtask
    task automatic stop_test;
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    always @(posedge i_clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            error_cnt++;
            stop_test();
        end
    end
    initial
    begin
        {i_rst_n, i_wr, i_rd, i_ring, i_set_ready, i_carrier, i_send_clear} = '0;
        {i_retry_limit_hit, i_no_ack_pulse, i_phase_code_error_pulse} = '0;
        {i_tx_dma_buffer_drained, i_rx_dma_buffer_filled, pv, i_addr, i_wdata} = '0;
        repeat (12) @(posedge i_clk);
        i_rst_n <= 1'b1;
        rc("drained off", OFF_CHANNEL_STATUS, 32'h200, 32'h0);
        wr(OFF_CONTROL, 32'h0b);
        wr(OFF_BAUD_DIVIDER, 32'h1);
        wr(OFF_EVENT_MASK, 32'h7f);
        rc("drained on", OFF_CHANNEL_STATUS, 32'h202, 32'h202);
        for (int k = 0; k < 4; k++)
        begin
            r = $random(seed);
            wr(OFF_TRANSMIT_HOLDING, hold(r[8:0], r[15]));
            rc("drained busy", OFF_CHANNEL_STATUS, 32'h200, 32'h0);
            repeat (14) @(posedge i_clk);
            chk("tx frame", 32'hfff, {20'h0, 1'b1, r[8:0], r[15], 1'b0}, {20'h0, got});
            peer_u.send(r[24:16], r[31]);
            repeat (4) @(posedge i_clk);
            rc("rx avail", OFF_CHANNEL_STATUS, 32'h1, 32'h1);
            rc("rx hold", OFF_RECEIVE_HOLDING, 32'h81ff, hold(r[24:16], r[31]));
            rc("rx avail clr", OFF_CHANNEL_STATUS, 32'h1, 32'h0);
            i_tx_dma_buffer_drained <= r[12];
            i_rx_dma_buffer_filled <= r[13];
            rc("dma", OFF_CHANNEL_STATUS, 32'h1800, {19'h0, r[13:12], 11'h0});
            {i_send_clear, i_carrier, i_set_ready, i_ring} <= r[3:0];
            repeat (5) @(posedge i_clk);
            rc("modem", 8'h00, 32'hff0000, {8'h0, r[3:0], r[3:0] ^ pv, 16'h0});
            pv = r[3:0];
        end
        {i_retry_limit_hit, i_no_ack_pulse, i_phase_code_error_pulse} <= 3'b111;
        @(posedge i_clk);
        {i_retry_limit_hit, i_no_ack_pulse, i_phase_code_error_pulse} <= 3'b000;
        rc("sticky", 8'h00, 32'h1002400, 32'h1002400);
        wr(OFF_COMMAND, 32'h1);
        rc("clr status", 8'h00, 32'h1002400, 32'h2400);
        wr(OFF_COMMAND, 32'h2);
        rc("clr no_acknowledge_seen", 8'h00, 32'h1002400, 32'h400);
        wr(OFF_COMMAND, 32'h4);
        rc("clr retry", 8'h00, 32'h1002400, 32'h0);
        chk("irq on", 32'h1, 32'h1, {31'h0, o_irq});
        wr(OFF_EVENT_STATUS, 32'h7f);
        wr(OFF_EVENT_MASK, 32'h0);
        i_no_ack_pulse <= 1'b1;
        @(posedge i_clk);
        i_no_ack_pulse <= 1'b0;
        repeat (3) @(posedge i_clk);
        chk("irq masked", 32'h1, 32'h0, {31'h0, o_irq});
        wr(OFF_EVENT_MASK, 32'h10);
        repeat (2) @(posedge i_clk);
        chk("irq unmasked", 32'h1, 32'h1, {31'h0, o_irq});
        rc("unmapped", 8'h40, 32'hffffffff, 32'h0);
        wr(OFF_BAUD_DIVIDER, 32'h0);
        wr(OFF_TRANSMIT_HOLDING, 32'h55);
        repeat (20) @(posedge i_clk);
        chk("baud stopped", 32'h1, 32'h1, {31'h0, o_txd});
        rc("drained stalled", 8'h00, 32'h200, 32'h0);
        stop_test();
    end
endmodule
